// >>> uart_chan_pkg.sv
// constants, register map and carrier types for the serial port channel
// assumes one 40 MHz clock and a single-master ahb-lite register bus
`default_nettype none
package uart_chan_pkg;
	localparam logic [4:0] off_data_idx   = 5'h00;
	localparam logic [4:0] off_ier_idx    = 5'h01;
	localparam logic [4:0] off_iir_idx    = 5'h02;
	localparam logic [4:0] off_lcr_idx    = 5'h03;
	localparam logic [4:0] off_mcr_idx    = 5'h04;
	localparam logic [4:0] off_lsr_idx    = 5'h05;
	localparam logic [4:0] off_msr_idx    = 5'h06;
	localparam logic [4:0] off_scr_idx    = 5'h07;
	localparam logic [4:0] off_shadow_idx = 5'h08;
	localparam logic [4:0] off_power_idx  = 5'h09;
	localparam logic [4:0] off_evstat_idx = 5'h0a;
	localparam logic [4:0] off_evclr_idx  = 5'h0b;
	localparam logic [4:0] off_evena_idx  = 5'h0c;
	localparam logic [4:0] off_rxin_idx   = 5'h0d;
	localparam logic [4:0] off_txout_idx  = 5'h0e;

	localparam int lcr_divisor_access_bit_bit   = 7;
	localparam int fcr_enable_bit = 0;
	localparam int fcr_dma_bit    = 3;
	localparam int mcr_loop_bit   = 4;
	localparam logic [7:0] iir_reset_val = 8'h01;
	localparam logic [7:0] lsr_reset_val = 8'h60;
	localparam logic [7:0] ier_mask      = 8'h0f;
	localparam logic [7:0] mcr_mask      = 8'h1f;
	localparam logic [7:0] fcr_keep_mask = 8'hc1;
	localparam logic [7:0] iir_fifo_bits = 8'hc8;
	localparam logic [7:0] lsr_fifo_err  = 8'h80;
	localparam logic [7:0] zero_byte     = 8'h00;
	localparam logic [31:0] zero_word    = 32'h0000_0000;

	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic [2:0] hsize_word    = 3'h2;

	typedef struct packed {
		logic carrier;
		logic ring;
		logic set_ready;
		logic clear_send;
	} modem_in_type;

	typedef struct packed {
		logic serial_out;
		logic send_request_out;
		logic terminal_ready_out;
	} line_out_type;

	typedef struct packed {
		logic modem;
		logic line;
		logic tx_empty;
		logic rx_avail;
	} ev_type;
endpackage
`default_nettype wire

// >>> line_out_gate.sv
// output driver for one channel: registered levels and enables
// assumes the caller has decided powerdown and pin-mux selection
`timescale 1ns/1ps
`default_nettype none
module line_out_gate
	import uart_chan_pkg::*;
(
	input  wire logic         clock_in,
	input  wire logic         srst_in,
	input  wire logic         powered_in,
	input  wire logic         serial_sel_in,
	input  wire line_out_type level_in,
	output var  line_out_type level_out,
	output var  line_out_type oe_out
);
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			oe_out <= '0;
		end else begin
			// shared pin left alone when another function owns it
			oe_out <= (powered_in && serial_sel_in) ? '1 : '0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			level_out <= '1;
		end else begin
			level_out <= level_in;
		end
	end
endmodule
`default_nettype wire

// >>> serial_port_channel_regs.sv
// register file of one serial port channel on an ahb-lite slave
// assumes hsel/htrans from one master, word transfers, one 40 MHz clock
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module serial_port_channel_regs
	import uart_chan_pkg::*;
#(
	parameter int channel_num = 1
)(
	input  wire logic         clock_in,
	input  wire logic         srst_in,
	input  wire logic         hsel_in,
	input  wire logic [31:0]  haddr_in,
	input  wire logic [1:0]   htrans_in,
	input  wire logic         hwrite_in,
	input  wire logic [2:0]   hsize_in,
	input  wire logic [31:0]  hwdata_in,
	input  wire logic         hready_in,
	output var  logic [31:0]  hrdata_out,
	output var  logic         hreadyout_out,
	output var  logic         hresp_out,
	input  wire logic         activate_cfg_in,
	input  wire logic         power_control_cfg_in,
	input  wire logic         serial_sel_in,
	input  wire logic         legacy_mode_in,
	input  wire logic         tx_shift_empty_in,
	input  wire modem_in_type modem_in,
	output var  line_out_type line_level_out,
	output var  line_out_type line_oe_out,
	output var  logic         irq_out
);
	initial begin
		if (channel_num < 1 || channel_num > 6)
			$error("channel_num must be 1 to 6");
	end

	logic [7:0]   ier_ff, lcr_ff, mcr_ff, scr_ff, fcr_ff;
	logic [7:0]   dll_ff, dlm_ff, rbr_ff, thr_ff;
	logic         thr_full_ff;
	logic [7:0]   tx_shift_ff;
	logic         wr_pend_ff;
	logic [4:0]   wr_idx_ff;
	modem_in_type modem_meta_ff, modem_sync_ff, modem_prev_ff;
	logic         shift_meta_ff, shift_sync_ff;
	logic [3:0]   msr_delta_ff;
	ev_type       ev_stat_ff, ev_ena_ff;
	logic         powered;
	logic         fifo_on;
	modem_in_type modem_eff;
	logic [3:0]   nxt_delta;
	ev_type       ev_now;
	logic [7:0]   iir_val, lsr_val, msr_val;
	logic         rd_go, wr_go;
	logic [4:0]   a_idx;
	line_out_type line_level;

	// decodes a word index from a byte address
	function automatic logic [4:0] word_index(input logic [31:0] a);
		return a[6:2];
	endfunction

	assign a_idx = word_index(haddr_in);
	assign rd_go = hsel_in && hready_in && htrans_in == htrans_nonseq &&
		!hwrite_in;
	assign wr_go = hsel_in && hready_in && htrans_in == htrans_nonseq &&
		hwrite_in;

	// channels beyond the second have no power bit
	assign powered = (channel_num <= 2) ?
		(activate_cfg_in && power_control_cfg_in) :
		activate_cfg_in;
	assign fifo_on = fcr_ff[fcr_enable_bit];

	always_ff @(posedge clock_in) begin
		modem_meta_ff <= modem_in;
		modem_sync_ff <= modem_meta_ff;
		shift_meta_ff <= tx_shift_empty_in;
		shift_sync_ff <= shift_meta_ff;
	end

	// loopback feeds modem control back into the modem inputs
	always_comb begin
		if (mcr_ff[mcr_loop_bit]) begin
			modem_eff.carrier    = mcr_ff[3];
			modem_eff.ring       = mcr_ff[2];
			modem_eff.set_ready  = mcr_ff[0];
			modem_eff.clear_send = mcr_ff[1];
		end else begin
			modem_eff = modem_sync_ff;
		end
	end

	always_comb begin
		nxt_delta[3] = modem_eff.carrier ^ modem_prev_ff.carrier;
		nxt_delta[2] = modem_prev_ff.ring && !modem_eff.ring;
		nxt_delta[1] = modem_eff.set_ready ^ modem_prev_ff.set_ready;
		nxt_delta[0] = modem_eff.clear_send ^ modem_prev_ff.clear_send;
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			modem_prev_ff <= '0;
			msr_delta_ff  <= '0;
		end else begin
			modem_prev_ff <= modem_eff;
			// a change in the read cycle still sets the delta
			if (rd_go && a_idx == off_msr_idx)
				msr_delta_ff <= nxt_delta;
			else
				msr_delta_ff <= msr_delta_ff | nxt_delta;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff  <= '0;
		end else begin
			wr_pend_ff <= wr_go;
			if (wr_go)
				wr_idx_ff <= a_idx;
		end
	end

	// control register writes land in the data phase
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			ier_ff <= zero_byte;
			lcr_ff <= zero_byte;
			mcr_ff <= zero_byte;
			fcr_ff <= zero_byte;
			scr_ff <= zero_byte;
			dll_ff <= zero_byte;
			dlm_ff <= zero_byte;
			ev_ena_ff <= '0;
		end else if (wr_pend_ff) begin
			unique case (wr_idx_ff)
			off_data_idx: begin
				if (lcr_ff[lcr_divisor_access_bit_bit])
					dll_ff <= hwdata_in[7:0];
			end
			off_ier_idx: begin
				if (lcr_ff[lcr_divisor_access_bit_bit])
					dlm_ff <= hwdata_in[7:0];
				else
					ier_ff <= hwdata_in[7:0] & ier_mask;
			end
			// dma select and the fifo reset strobes are not stored
			off_iir_idx: fcr_ff <= hwdata_in[7:0] & fcr_keep_mask;
			off_lcr_idx: lcr_ff <= hwdata_in[7:0];
			off_mcr_idx: mcr_ff <= hwdata_in[7:0] & mcr_mask;
			off_scr_idx: begin
				if (!legacy_mode_in)
					scr_ff <= hwdata_in[7:0];
			end
			off_evena_idx: ev_ena_ff <= hwdata_in[3:0];
			default: ;
			endcase
		end
	end

	// holding register and a software-visible shift image
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			thr_ff      <= zero_byte;
			thr_full_ff <= 1'b0;
			tx_shift_ff <= zero_byte;
		end else if (wr_pend_ff && wr_idx_ff == off_data_idx &&
				!lcr_ff[lcr_divisor_access_bit_bit]) begin
			thr_ff      <= hwdata_in[7:0];
			thr_full_ff <= 1'b1;
		end else if (thr_full_ff && shift_sync_ff) begin
			tx_shift_ff <= thr_ff;
			thr_full_ff <= 1'b0;
		end
	end

	// receive byte comes from the loopback path only in this block
	always_ff @(posedge clock_in) begin
		if (srst_in)
			rbr_ff <= zero_byte;
		else if (mcr_ff[mcr_loop_bit] && thr_full_ff && shift_sync_ff)
			rbr_ff <= thr_ff;
	end

	always_comb begin
		ev_now.rx_avail = 1'b0;
		ev_now.tx_empty = thr_full_ff && shift_sync_ff;
		ev_now.line     = 1'b0;
		ev_now.modem    = |nxt_delta;
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			ev_stat_ff <= '0;
		end else begin
			// a new event wins over a clear in the same cycle
			if (wr_pend_ff && wr_idx_ff == off_evclr_idx)
				ev_stat_ff <= (ev_stat_ff & ~ev_type'(hwdata_in[3:0])) |
					(ev_now & ier_ff[3:0]);
			else
				ev_stat_ff <= ev_stat_ff | (ev_now & ier_ff[3:0]);
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in)
			irq_out <= 1'b0;
		else
			irq_out <= |(ev_stat_ff & ev_ena_ff);
	end

	always_comb begin
		iir_val = iir_reset_val;
		if (|ev_stat_ff) begin
			iir_val[0] = 1'b0;
			iir_val[2:1] = ev_stat_ff.line ? 2'h3 :
				ev_stat_ff.rx_avail ? 2'h2 :
				ev_stat_ff.tx_empty ? 2'h1 : 2'h0;
		end
		if (fifo_on)
			iir_val = iir_val | (iir_fifo_bits & 8'hc0);
		else
			iir_val = iir_val & ~iir_fifo_bits;
	end

	always_comb begin
		lsr_val = zero_byte;
		lsr_val[5] = !thr_full_ff;
		// legacy mode: idle is the shift register alone
		lsr_val[6] = legacy_mode_in ? shift_sync_ff :
			(!thr_full_ff && shift_sync_ff);
		if (!fifo_on)
			lsr_val = lsr_val & ~lsr_fifo_err;
	end

	assign msr_val = {modem_eff.carrier, modem_eff.ring,
		modem_eff.set_ready, modem_eff.clear_send, msr_delta_ff};

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			hrdata_out <= zero_word;
		end else if (rd_go) begin
			unique case (a_idx)
			off_data_idx: hrdata_out <= {24'h0, lcr_ff[lcr_divisor_access_bit_bit] ?
				dll_ff : rbr_ff};
			off_ier_idx: hrdata_out <= {24'h0, lcr_ff[lcr_divisor_access_bit_bit] ?
				dlm_ff : ier_ff};
			off_iir_idx:    hrdata_out <= {24'h0, iir_val};
			off_lcr_idx:    hrdata_out <= {24'h0, lcr_ff};
			off_mcr_idx:    hrdata_out <= {24'h0, mcr_ff};
			off_lsr_idx:    hrdata_out <= {24'h0, lsr_val};
			off_msr_idx:    hrdata_out <= {24'h0, msr_val};
			off_scr_idx: hrdata_out <= {24'h0,
				legacy_mode_in ? zero_byte : scr_ff};
			off_shadow_idx: hrdata_out <= {24'h0, fcr_ff};
			off_power_idx:  hrdata_out <= {31'h0, powered};
			off_evstat_idx: hrdata_out <= {28'h0, ev_stat_ff};
			off_evena_idx:  hrdata_out <= {28'h0, ev_ena_ff};
			off_txout_idx:  hrdata_out <= {24'h0, tx_shift_ff};
			default:        hrdata_out <= zero_word;
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		hreadyout_out <= 1'b1;
		hresp_out     <= 1'b0;
	end

	// line levels are active low for the two modem outputs
	always_comb begin
		line_level.serial_out = !lcr_ff[6];
		line_level.send_request_out = mcr_ff[mcr_loop_bit] || !mcr_ff[1];
		line_level.terminal_ready_out = mcr_ff[mcr_loop_bit] || !mcr_ff[0];
	end

	line_out_gate u_gate (
		.clock_in      (clock_in),
		.srst_in       (srst_in),
		.powered_in    (powered),
		.serial_sel_in (serial_sel_in),
		.level_in      (line_level),
		.level_out     (line_level_out),
		.oe_out        (line_oe_out)
	);
endmodule
`default_nettype wire

// >>> serial_port_channel_regs_chk.sv
// assertions on the serial port channel: power gating and register reads
// assumes the one ahb-lite master ties hready_in to hreadyout_out
`timescale 1ns/1ps
`default_nettype none
module serial_port_channel_regs_chk
	import uart_chan_pkg::*;
#(
	parameter int channel_num = 1
)(
	input wire logic         clock_in,
	input wire logic         srst_in,
	input wire logic         hsel_in,
	input wire logic [31:0]  haddr_in,
	input wire logic [1:0]   htrans_in,
	input wire logic         hwrite_in,
	input wire logic [31:0]  hwdata_in,
	input wire logic         hready_in,
	input wire logic [31:0]  hrdata_out,
	input wire logic         hreadyout_out,
	input wire logic         hresp_out,
	input wire logic         activate_cfg_in,
	input wire logic         power_control_cfg_in,
	input wire logic         serial_sel_in,
	input wire line_out_type line_oe_out
);
	logic       rd_ff;
	logic       wr_ff;
	logic       divisor_access_bit_ff;
	logic       fen_ff;
	logic [4:0] idx_ff;
	wire  logic take = hsel_in && hready_in && htrans_in == htrans_nonseq;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (srst_in);
	// data phase tracking, so reads are judged against the bank state
	always_ff @(posedge clock_in) begin
		rd_ff <= !srst_in && take && !hwrite_in;
		wr_ff <= !srst_in && take && hwrite_in;
		idx_ff <= haddr_in[6:2];
	end
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			divisor_access_bit_ff <= 1'b0;
			fen_ff <= 1'b0;
		end else if (wr_ff && idx_ff == off_lcr_idx) begin
			divisor_access_bit_ff <= hwdata_in[lcr_divisor_access_bit_bit];
		end else if (wr_ff && idx_ff == off_iir_idx) begin
			fen_ff <= hwdata_in[fcr_enable_bit];
		end
	end
	property p_reset_hiz;
		$fell(srst_in) |-> line_oe_out == 3'h0;
	endproperty
	a_reset_hiz: assert property (p_reset_hiz)
		else $error("pins driven right after reset");
	property p_power_off;
		!activate_cfg_in || (channel_num <= 2 && !power_control_cfg_in)
			|=> line_oe_out == 3'h0;
	endproperty
	a_power_off: assert property (p_power_off)
		else $error("pins driven in powerdown");
	property p_power_on;
		activate_cfg_in && serial_sel_in
			&& (channel_num > 2 || power_control_cfg_in) |=> line_oe_out == 3'h7;
	endproperty
	a_power_on: assert property (p_power_on)
		else $error("pins idle while powered");
	property p_mux_off;
		!serial_sel_in |=> line_oe_out == 3'h0;
	endproperty
	a_mux_off: assert property (p_mux_off)
		else $error("pins driven while not selected");
	property p_ier_top;
		rd_ff && idx_ff == off_ier_idx && !divisor_access_bit_ff |-> hrdata_out[7:4] == 4'h0;
	endproperty
	a_ier_top: assert property (p_ier_top)
		else $error("upper enable bits not zero");
	property p_iir_nofifo;
		rd_ff && idx_ff == off_iir_idx && !fen_ff
			|-> (hrdata_out[7:0] & iir_fifo_bits) == zero_byte;
	endproperty
	a_iir_nofifo: assert property (p_iir_nofifo)
		else $error("fifo bits set in identification");
	property p_lsr_nofifo;
		rd_ff && idx_ff == off_lsr_idx && !fen_ff
			|-> (hrdata_out[7:0] & lsr_fifo_err) == zero_byte;
	endproperty
	a_lsr_nofifo: assert property (p_lsr_nofifo)
		else $error("fifo error set in line state");
	property p_bus_ok;
		take |=> hreadyout_out && !hresp_out;
	endproperty
	a_bus_ok: assert property (p_bus_ok)
		else $error("data phase not ready or not okay");
	c_ier_read: cover property (rd_ff && idx_ff == off_ier_idx);
	c_divisor: cover property (divisor_access_bit_ff && wr_ff);
	c_powerdown: cover property ($fell(line_oe_out.serial_out));
endmodule
bind serial_port_channel_regs serial_port_channel_regs_chk
	#(.channel_num(channel_num)) chk_i (.*);
`default_nettype wire

// >>> modem_peer.sv
// modem equipment at the line side, driving the four modem inputs
// assumes the bench sets the wanted levels between clock edges
`timescale 1ns/1ps
`default_nettype none
module modem_peer
	import uart_chan_pkg::*;
(
	input  wire logic         clock_in,
	input  wire modem_in_type want_in,
	output var  modem_in_type modem_out
);
	initial modem_out = 4'h0;
	always @(posedge clock_in) begin
		modem_out <= want_in;
	end
endmodule
`default_nettype wire

// >>> serial_port_channel_regs_tb.sv
// self-checking bench for one serial port channel, channel one
// assumes a single ahb-lite master; hready loops back from the slave
`timescale 1ns/1ps
`default_nettype none
module serial_port_channel_regs_tb
	import uart_chan_pkg::*;
;
	logic         clock_in = 1'b0;
	logic         srst_in  = 1'b1;
	logic         hsel     = 1'b0;
	logic         hwrite   = 1'b0;
	logic [31:0]  haddr    = zero_word;
	logic [31:0]  hwdata   = zero_word;
	logic [1:0]   htrans   = 2'h0;
	logic [2:0]   hsize    = hsize_word;
	logic [2:0]   pw       = 3'h0;
	logic         leg      = 1'b0;
	logic         txe      = 1'b1;
	modem_in_type want     = 4'h0;
	logic [2:0]   pws [4]  = '{3'h7, 3'h3, 3'h5, 3'h6};
	logic [31:0]  hrdata;
	logic [31:0]  r;
	logic         hrdy;
	logic         hresp;
	logic         irq;
	modem_in_type mdm;
	line_out_type lvl;
	line_out_type oe;
	line_out_type l0;
	int           num_errors = 0;
	int           n_tests    = 0;
	always #12.5 clock_in = ~clock_in;
	serial_port_channel_regs dut (
		.clock_in(clock_in), .srst_in(srst_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hrdy),
		.hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
		.activate_cfg_in(pw[2]), .power_control_cfg_in(pw[1]),
		.serial_sel_in(pw[0]), .legacy_mode_in(leg),
		.tx_shift_empty_in(txe), .modem_in(mdm), .line_level_out(lvl),
		.line_oe_out(oe), .irq_out(irq));
	modem_peer peer (.clock_in(clock_in), .want_in(want), .modem_out(mdm));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	// one single transfer; entered just after a rising edge
	task automatic xfer(input logic w, input logic [4:0] i,
			input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {25'h0, i, 2'h0};
		htrans <= htrans_nonseq;
		hwrite <= w;
		do @(posedge clock_in); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock_in); while (hrdy !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		xfer(1'b1, i, {24'h0, d}, r);
	endtask
	task automatic rc(input logic [4:0] i, input logic [7:0] e,
			input logic [7:0] m);
		xfer(1'b0, i, zero_word, r);
		chk(r & {24'h0, m}, {24'h0, e});
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#100us;
		num_errors++;
		print_verdict();
	end
	initial begin
		tick(6);
		srst_in <= 1'b0;
		tick(1);
		chk(oe, 3'h0);
		chk({hrdy, hresp}, 2'h2);
		rc(off_ier_idx, 8'h00, 8'hff);
		rc(off_iir_idx, iir_reset_val, 8'hff);
		rc(off_lcr_idx, 8'h00, 8'hff);
		rc(off_mcr_idx, 8'h00, 8'hff);
		rc(off_lsr_idx, lsr_reset_val, 8'hff);
		rc(off_msr_idx, 8'h00, 8'h0f);
		wr(off_rxin_idx, 8'h77);
		rc(off_rxin_idx, 8'h00, 8'hff);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			pw <= pws[i];
			tick(3);
			chk(oe, {3{pws[i] == 3'h7}});
		end
		pw <= 3'h7;
		$display("test power done");
		wr(off_lcr_idx, 8'h80);
		wr(off_data_idx, 8'h12);
		wr(off_ier_idx, 8'h34);
		rc(off_data_idx, 8'h12, 8'hff);
		rc(off_ier_idx, 8'h34, 8'hff);
		wr(off_lcr_idx, 8'h00);
		rc(off_ier_idx, 8'h00, 8'hff);
		wr(off_ier_idx, 8'hff);
		rc(off_ier_idx, ier_mask, 8'hff);
		wr(off_lcr_idx, 8'h7f);
		rc(off_lcr_idx, 8'h7f, 8'hff);
		wr(off_lcr_idx, 8'h00);
		wr(off_iir_idx, 8'h09);
		rc(off_shadow_idx, 8'h01, 8'hff);
		wr(off_iir_idx, 8'h00);
		rc(off_iir_idx, 8'h00, iir_fifo_bits);
		rc(off_lsr_idx, 8'h00, lsr_fifo_err);
		$display("test bank done");
		l0 = lvl;
		wr(off_mcr_idx, 8'h0c);
		tick(2);
		chk(lvl, l0);
		rc(off_mcr_idx, 8'h0c, 8'hff);
		wr(off_mcr_idx, 8'h1f);
		tick(4);
		rc(off_msr_idx, 8'hf0, 8'hf0);
		wr(off_mcr_idx, 8'h00);
		want <= 4'ha;
		tick(4);
		rc(off_msr_idx, 8'ha0, 8'hf0);
		$display("test modem done");
		wr(off_ier_idx, 8'h08);
		wr(off_evena_idx, 8'h00);
		wr(off_evclr_idx, 8'h0f);
		want <= 4'h5;
		tick(4);
		rc(off_evstat_idx, 8'h08, 8'h0f);
		chk(irq, 1'b0);
		wr(off_evena_idx, 8'h08);
		tick(2);
		chk(irq, 1'b1);
		wr(off_evclr_idx, 8'h08);
		tick(2);
		rc(off_evstat_idx, 8'h00, 8'h0f);
		chk(irq, 1'b0);
		$display("test irq done");
		wr(off_scr_idx, 8'h5a);
		leg <= 1'b1;
		txe <= 1'b0;
		tick(4);
		wr(off_scr_idx, 8'ha5);
		rc(off_lsr_idx, 8'h00, 8'h40);
		txe <= 1'b1;
		tick(4);
		rc(off_lsr_idx, 8'h40, 8'h40);
		leg <= 1'b0;
		tick(2);
		rc(off_scr_idx, 8'h5a, 8'hff);
		$display("test legacy done");
		// loopback: the held byte reaches the receive buffer unchanged
		wr(off_mcr_idx, 8'h10);
		wr(off_data_idx, 8'h81);
		tick(2);
		rc(off_data_idx, 8'h81, 8'hff);
		rc(off_txout_idx, 8'h81, 8'hff);
		wr(off_mcr_idx, 8'h00);
		$display("test loopback done");
		srst_in <= 1'b1;
		tick(2);
		chk(oe, 3'h0);
		srst_in <= 1'b0;
		tick(1);
		rc(off_lcr_idx, 8'h00, 8'hff);
		$display("test rereset done");
		print_verdict();
	end
endmodule
`default_nettype wire
